// file: sac_top.sv
// sac_top.sv: converter start, accumulate and format control with register slave
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  input wire logic aclk, // system clock, 20 MHz
  input wire logic aresetn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic timer0_ovf, // timer 0 overflow pulse
  input wire logic timer2_lo_ovf, // timer 2 low byte overflow
  input wire logic timer2_hi_ovf, // timer 2 high byte overflow
  input wire logic timer2_16bit, // timer 2 in 16-bit mode
  input wire logic timer3_lo_ovf, // timer 3 low byte overflow
  input wire logic timer3_hi_ovf, // timer 3 high byte overflow
  input wire logic timer3_16bit, // timer 3 in 16-bit mode
  input wire logic ext_start_input, // external start pin
  input wire logic lfo_clk_in, // low-power oscillator pin
  input wire logic dcdc_clk_in, // supply converter clock pin
  input wire logic [9:0] sar_code, // code from the sar core
  output logic sar_track, // sampling switch closed
  output logic sar_convert, // sar core converting
  output logic conv_busy, // conversion in progress
  output logic conv_done // conversion done flag
);
  //--------------------------------------------------
  // state
  //--------------------------------------------------
  sac_state_t state, next_state;
  logic [2:0] start_mode_sel;
  logic burst_enable, low_power_track_bit, sync_enable, sync_clock_invert;
  logic [4:0] conv_clock_div_field;
  logic [2:0] justify_shift_sel, repeat_count_sel;
  logic conv_done_flag;
  logic [7:0] result_high_byte, result_low_byte;
  logic [15:0] acc, acc_next, res_fmt, left_exp;
  logic [6:0] n_cnt;
  logic [3:0] cnt;
  logic ext_s1, ext_s2, ext_s3, ext_rise;
  logic wr_go, rd_go, wr_hit, rd_hit, sw_start, done_clr;
  logic trig, run, conv_tick, sync_pulse, conv_end, last, chain, series_end;
  logic conv_busy_bit;
  logic [31:0] rd_mux;
  sac_state_t first_st;
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a >> 4) == '0;
  endfunction : reg_hit
  //--------------------------------------------------
  // register slave handshake
  //--------------------------------------------------
  assign wr_go = ce & awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign rd_go = ce & arvalid & ~rvalid;
  assign arready = rd_go;
  assign wr_hit = wr_go & reg_hit(awaddr);
  assign rd_hit = reg_hit(araddr);
  assign sw_start = wr_hit & (awaddr[3:0] == OFF_CTRL) & wstrb[1] & wdata[F_BUSY]
                    & (start_mode_sel == MODE_SW);
  assign done_clr = wr_hit & (awaddr[3:0] == OFF_CTRL) & wstrb[1] & ~wdata[F_DONE];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= reg_hit(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end
  always_comb
  begin
    rd_mux = 32'h0;
    case (araddr[3:0])
      OFF_CTRL:
      begin
        rd_mux[F_MODE +: 3] = start_mode_sel;
        rd_mux[F_BURST] = burst_enable;
        rd_mux[F_LPT] = low_power_track_bit;
        rd_mux[F_SYNC] = sync_enable;
        rd_mux[F_INV] = sync_clock_invert;
        rd_mux[F_BUSY] = conv_busy_bit;
        rd_mux[F_DONE] = conv_done_flag;
      end
      OFF_CFG:
      begin
        rd_mux[F_DIV +: 5] = conv_clock_div_field;
        rd_mux[F_JST +: 3] = justify_shift_sel;
        rd_mux[F_RPT +: 3] = repeat_count_sel;
      end
      OFF_RES_LO: rd_mux[7:0] = result_low_byte;
      OFF_RES_HI: rd_mux[7:0] = result_high_byte;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata <= rd_hit ? rd_mux : 32'h0;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end
  //--------------------------------------------------
  // control and configuration registers
  //--------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_mode_sel <= RST_MODE;
      {burst_enable, low_power_track_bit, sync_enable, sync_clock_invert} <= 4'h0;
      conv_clock_div_field <= RST_DIV;
      justify_shift_sel <= RST_JST;
      repeat_count_sel <= RST_RPT;
    end
    else if (ce && wr_hit)
    begin
      if (awaddr[3:0] == OFF_CTRL && wstrb[0])
      begin
        start_mode_sel <= wdata[F_MODE +: 3];
        burst_enable <= wdata[F_BURST];
        low_power_track_bit <= wdata[F_LPT];
        sync_enable <= wdata[F_SYNC];
        sync_clock_invert <= wdata[F_INV];
      end
      if (awaddr[3:0] == OFF_CFG)
      begin
        if (wstrb[0])
          conv_clock_div_field <= wdata[F_DIV +: 5];
        if (wstrb[1])
          justify_shift_sel <= wdata[F_JST +: 3];
        if (wstrb[2])
          repeat_count_sel <= wdata[F_RPT +: 3];
      end
    end
  end
  // done flag: set by series end wins over a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_done_flag <= 1'b0;
    else if (ce)
    begin
      if (series_end)
        conv_done_flag <= 1'b1;
      else if (done_clr)
        conv_done_flag <= 1'b0;
    end
  end
  //--------------------------------------------------
  // trigger selection
  //--------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {ext_s1, ext_s2, ext_s3} <= 3'h0;
    else if (ce)
      {ext_s1, ext_s2, ext_s3} <= {ext_start_input, ext_s1, ext_s2};
  end
  assign ext_rise = ext_s2 & ~ext_s3;
  always_comb
  begin
    case (start_mode_sel)
      MODE_SW: trig = sw_start;
      MODE_T0: trig = timer0_ovf;
      MODE_T2: trig = timer2_16bit ? timer2_hi_ovf : timer2_lo_ovf;
      MODE_T3: trig = timer3_16bit ? timer3_hi_ovf : timer3_lo_ovf;
      MODE_EXT: trig = ext_rise;
      default: trig = 1'b0;
    endcase
  end
  //--------------------------------------------------
  // conversion sequencer
  //--------------------------------------------------
  sac_clkgen #(.DIV_W(5)) u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .lfo_clk_in(lfo_clk_in),
    .dcdc_clk_in(dcdc_clk_in),
    .burst_enable(burst_enable),
    .sync_enable(sync_enable),
    .sync_clock_invert(sync_clock_invert),
    .div_field(conv_clock_div_field),
    .run(run),
    .conv_tick(conv_tick),
    .sync_pulse(sync_pulse)
  );
  assign run = (state == ST_TRACK) | (state == ST_CONV);
  assign first_st = low_power_track_bit ? ST_TRACK : ST_CONV;
  assign conv_end = (state == ST_CONV) & conv_tick & (cnt == CONV_END);
  assign last = (n_cnt + 7'h01) == repeat_len(repeat_count_sel);
  assign series_end = conv_end & last;
  assign chain = burst_enable & (start_mode_sel != MODE_EXT) & ~last;
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (trig)
          next_state = sync_enable ? ST_WSYNC : first_st;
      ST_WSYNC:
        if (sync_pulse)
          next_state = first_st;
      ST_TRACK:
        if (conv_tick && cnt == TRACK_END)
          next_state = ST_CONV;
      ST_CONV:
        if (conv_end)
          next_state = chain ? first_st : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= ST_IDLE;
    else if (ce)
      state <= next_state;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt <= 4'h0;
    else if (ce)
    begin
      if (state != next_state || conv_end)
        cnt <= 4'h0;
      else if (conv_tick)
        cnt <= cnt + 4'h1;
    end
  end
  assign conv_busy_bit = state != ST_IDLE;
  assign conv_busy = conv_busy_bit;
  assign conv_done = conv_done_flag;
  assign sar_convert = state == ST_CONV;
  assign sar_track = (state == ST_TRACK) | (~low_power_track_bit & (state != ST_CONV));
  //--------------------------------------------------
  // accumulate and format
  //--------------------------------------------------
  assign acc_next = ((n_cnt == 7'h00) ? 16'h0000 : acc) + {6'h00, sar_code};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc <= 16'h0000;
      n_cnt <= 7'h00;
    end
    else if (ce && conv_end)
    begin
      acc <= acc_next;
      n_cnt <= last ? 7'h00 : n_cnt + 7'h01;
    end
  end
  sac_format u_format (
    .acc(acc_next),
    .jst(justify_shift_sel),
    .res(res_fmt)
  );
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {result_high_byte, result_low_byte} <= 16'h0000;
    else if (ce && series_end)
      {result_high_byte, result_low_byte} <= res_fmt;
  end
  //--------------------------------------------------
  // checks
  //--------------------------------------------------
  assign left_exp = {acc_next[9:0], 6'h00};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_right_fmt: assert property (series_end && justify_shift_sel == JST_RIGHT
    |=> {result_high_byte, result_low_byte} == $past(acc_next)) else $error("right-justified result wrong");
  a_left_fmt: assert property (series_end && justify_shift_sel == JST_LEFT
    |=> {result_high_byte, result_low_byte} == $past(left_exp)) else $error("left-justified result wrong");
  a_unused_zero: assert property (series_end && justify_shift_sel == JST_RIGHT && repeat_count_sel == RPT_ONE
    |=> result_high_byte[7:2] == 6'h00) else $error("unused result bits not zero");
  a_shift_three: assert property (series_end && justify_shift_sel == JST_SHR3
    |=> {result_high_byte, result_low_byte} == ($past(acc_next) >> 3)) else $error("shift by three wrong");
  a_result_hold: assert property (!series_end
    |=> $stable({result_high_byte, result_low_byte})) else $error("result changed inside a series");
  a_acc_clear: assert property (conv_end && n_cnt == 7'h00
    |=> acc == {6'h00, $past(sar_code)}) else $error("accumulator not restarted");
  a_acc_sum: assert property (conv_end && n_cnt != 7'h00
    |=> acc == $past(acc) + {6'h00, $past(sar_code)}) else $error("accumulator sum wrong");
  a_done_set: assert property ($rose(conv_done_flag) |-> $past(series_end))
    else $error("done flag set without series end");
  a_done_wait: assert property (conv_end && !last && !done_clr |=> $stable(conv_done_flag))
    else $error("done flag moved before full count");
  a_sw_start: assert property (sw_start && state == ST_IDLE |=> conv_busy_bit)
    else $error("software start ignored");
  a_busy_end: assert property (conv_end && !chain |=> !conv_busy_bit)
    else $error("busy not cleared at completion");
  a_ext_start: assert property (ce && ext_rise && start_mode_sel == MODE_EXT && state == ST_IDLE
    |=> state != ST_IDLE) else $error("external edge did not start");
  a_t2_sel: assert property (ce && start_mode_sel == MODE_T2 && timer2_16bit && !timer2_hi_ovf
    && state == ST_IDLE |=> state == ST_IDLE) else $error("timer 2 low overflow used in 16-bit mode");
  a_sync_hold: assert property (state == ST_WSYNC && !sync_pulse |=> state == ST_WSYNC)
    else $error("start left sync wait early");
  a_track_len: assert property ($rose(state == ST_CONV) && $past(state) == ST_TRACK
    |-> $past(cnt) == TRACK_END && $past(conv_tick)) else $error("tracking length wrong");
  c_burst_series: cover property (series_end && burst_enable && repeat_count_sel != RPT_ONE);
  c_ext_start: cover property (ext_rise && start_mode_sel == MODE_EXT && state == ST_IDLE);
  c_sync_exit: cover property (state == ST_WSYNC ##1 state == ST_TRACK);
endmodule : sac_top

// file: sac_pkg.sv
// sac_pkg.sv: constants, types and helpers for the converter start, accumulate and format control
package sac_pkg;
  //--------------------------------------------------
  // register map and fields
  //--------------------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CFG = 4'h4;
  localparam logic [3:0] OFF_RES_LO = 4'h8;
  localparam logic [3:0] OFF_RES_HI = 4'hc;
  localparam int F_MODE = 0;
  localparam int F_BURST = 3;
  localparam int F_LPT = 4;
  localparam int F_SYNC = 5;
  localparam int F_INV = 6;
  localparam int F_BUSY = 8;
  localparam int F_DONE = 9;
  localparam int F_DIV = 0;
  localparam int F_JST = 8;
  localparam int F_RPT = 16;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [4:0] RST_DIV = 5'h1f;
  localparam logic [2:0] RST_JST = 3'h0;
  localparam logic [2:0] RST_RPT = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  //--------------------------------------------------
  // modes and timing
  //--------------------------------------------------
  localparam logic [2:0] MODE_SW = 3'h0;
  localparam logic [2:0] MODE_T0 = 3'h1;
  localparam logic [2:0] MODE_T2 = 3'h2;
  localparam logic [2:0] MODE_T3 = 3'h3;
  localparam logic [2:0] MODE_EXT = 3'h4;
  localparam logic [2:0] JST_RIGHT = 3'h0;
  localparam logic [2:0] JST_SHR1 = 3'h1;
  localparam logic [2:0] JST_SHR2 = 3'h2;
  localparam logic [2:0] JST_SHR3 = 3'h3;
  localparam logic [2:0] JST_LEFT = 3'h4;
  localparam logic [2:0] RPT_ONE = 3'h0;
  localparam int TRACK_CLKS = 3;
  localparam int CONV_CLKS = 11;
  localparam logic [3:0] TRACK_END = 4'(TRACK_CLKS - 1);
  localparam logic [3:0] CONV_END = 4'(CONV_CLKS - 1);
  localparam int CLK_NS = 50;
  localparam int SYNC_MAX_NS = 625;
  localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_NS;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WSYNC = 4'b0010,
    ST_TRACK = 4'b0100,
    ST_CONV = 4'b1000
  } sac_state_t;
  // samples per series for the repeat field
  function automatic logic [6:0] repeat_len(input logic [2:0] sel);
    case (sel)
      3'h1: repeat_len = 7'h04;
      3'h2: repeat_len = 7'h08;
      3'h3: repeat_len = 7'h10;
      3'h4: repeat_len = 7'h20;
      3'h5: repeat_len = 7'h40;
      default: repeat_len = 7'h01;
    endcase
  endfunction : repeat_len
endpackage : sac_pkg

// file: sac_format.sv
// sac_format.sv: justify and shift of the accumulated result
`timescale 1ns/1ps
module sac_format
  import sac_pkg::*;
(
  input wire logic [15:0] acc, // accumulated sum
  input wire logic [2:0] jst, // justify/shift select
  output logic [15:0] res // formatted result
);
  always_comb
  begin
    case (jst)
      JST_SHR1: res = {1'b0, acc[15:1]};
      JST_SHR2: res = {2'h0, acc[15:2]};
      JST_SHR3: res = {3'h0, acc[15:3]};
      JST_LEFT: res = {acc[9:0], 6'h00};
      default: res = acc;
    endcase
  end
endmodule : sac_format

// file: sac_clkgen.sv
// sac_clkgen.sv: conversion clock tick and converter sync pulse
`timescale 1ns/1ps
module sac_clkgen
  import sac_pkg::*;
#(
  parameter int DIV_W = 5
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic lfo_clk_in, // low-power oscillator pin
  input wire logic dcdc_clk_in, // supply converter clock pin
  input wire logic burst_enable, // burst mode
  input wire logic sync_enable, // converter sync
  input wire logic sync_clock_invert, // invert converter clock
  input wire logic [DIV_W-1:0] div_field, // divide by field+1
  input wire logic run, // conversion in progress
  output logic conv_tick, // one conversion clock
  output logic sync_pulse // converter sync event
);
  logic lfo_s1, lfo_s2, lfo_s3;
  logic dc_s1, dc_s2, dc_s3;
  logic [DIV_W-1:0] cnt;
  logic src_tick;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {lfo_s1, lfo_s2, lfo_s3} <= 3'h0;
      {dc_s1, dc_s2, dc_s3} <= 3'h0;
    end
    else if (ce)
    begin
      {lfo_s1, lfo_s2, lfo_s3} <= {lfo_clk_in, lfo_s1, lfo_s2};
      {dc_s1, dc_s2, dc_s3} <= {dcdc_clk_in, dc_s1, dc_s2};
    end
  end
  assign sync_pulse = ce & (sync_clock_invert ? (dc_s3 & ~dc_s2) : (dc_s2 & ~dc_s3));
  always_comb
  begin
    if (sync_enable)
      src_tick = sync_pulse;
    else if (burst_enable)
      src_tick = ce & lfo_s2 & ~lfo_s3;
    else
      src_tick = ce;
  end
  assign conv_tick = run & src_tick & (cnt == div_field);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt <= '0;
    else if (ce)
    begin
      if (!run)
        cnt <= '0;
      else if (src_tick)
        cnt <= (cnt == div_field) ? '0 : cnt + 1'b1;
    end
  end
  a_sys_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
    run && !burst_enable && !sync_enable && div_field == '0 && ce |-> conv_tick)
    else $error("system clock tick missing at ratio one");
  a_sync_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    run && sync_enable && div_field == '0 |-> conv_tick == sync_pulse)
    else $error("converter clock not used for conversion");
  a_inv_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_enable && sync_clock_invert && conv_tick |-> $past(dc_s2) && !dc_s2)
    else $error("inverted clock tick on wrong edge");
endmodule : sac_clkgen

// file: sac_far_side.sv
// sac_far_side.sv: model of the sar core and the two free-running oscillators
`timescale 1ns/1ps
module sac_far_side
(
  input wire logic sar_convert, // core converting
  input wire logic [9:0] code_set, // code the core resolves
  output logic [9:0] sar_code, // code to the control
  output logic lfo_clk_in, // low-power oscillator
  output logic dcdc_clk_in // supply converter clock
);
  // -----------------------------------------
  // core and oscillators
  // -----------------------------------------
  // outside a conversion the code is not valid, so show a wrong value
  assign sar_code = sar_convert ? code_set : ~code_set;
  initial lfo_clk_in = 1'b0;
  initial dcdc_clk_in = 1'b0;
  always #90 lfo_clk_in = ~lfo_clk_in;
  always #141 dcdc_clk_in = ~dcdc_clk_in;
endmodule : sac_far_side

// file: tb_sac_top.sv
// tb_sac_top.sv: register-level bench for the converter control block
`timescale 1ns/1ps
module tb_sac_top;
  import sac_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, t16 = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sar_track, sar_convert, conv_busy, conv_done;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, r;
  logic [5:0] trig = '0;
  logic [9:0] code_set = '0, sar_code;
  logic lfo_clk_in, dcdc_clk_in;
  int failures = 0, check_count = 0, n;
  // code, justify, repeat code, expected result
  logic [35:0] tbl [10] = '{36'h3ff0003ff, 36'h3ff40ffc0, 36'h200408000, 36'h3ff010ffc, 36'h3ff1107fe,
    36'h1ff020ff8, 36'h1ff2307fc, 36'h3ff047fe0, 36'h3ff351ff8, 36'h3ff05ffc0};
  // mode, 16-bit, ignored source, starting source
  logic [15:0] trg [6] = '{16'h1010, 16'h2021, 16'h2112, 16'h3043, 16'h3134, 16'h4005};
  always #25 aclk = ~aclk;
  // -----------------------------------------
  // design and far side
  // -----------------------------------------
  sac_top u_sac_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .timer0_ovf(trig[0]), .timer2_lo_ovf(trig[1]),
    .timer2_hi_ovf(trig[2]), .timer2_16bit(t16), .timer3_lo_ovf(trig[3]), .timer3_hi_ovf(trig[4]),
    .timer3_16bit(t16), .ext_start_input(trig[5]), .lfo_clk_in(lfo_clk_in), .dcdc_clk_in(dcdc_clk_in),
    .sar_code(sar_code), .sar_track(sar_track), .sar_convert(sar_convert), .conv_busy(conv_busy),
    .conv_done(conv_done));
  sac_far_side u_sac_far_side (.sar_convert(sar_convert), .code_set(code_set), .sar_code(sar_code),
    .lfo_clk_in(lfo_clk_in), .dcdc_clk_in(dcdc_clk_in));
  // -----------------------------------------
  // tasks
  // -----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask : tick
  function automatic logic sig(input int s);
    case (s)
      0: return bvalid;
      1: return rvalid;
      2: return conv_done;
      default: return conv_busy;
    endcase
  endfunction : sig
  task automatic wait_sig(input int s, input logic v);
    int k;
    k = 0;
    while (sig(s) !== v)
    begin
      tick(1);
      k++;
      if (k > 3000)
      begin
        failures++;
        print_verdict();
      end
    end
  endtask : wait_sig
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] s);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tick(1);
    wait_sig(0, 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    r = bresp;
    tick(1);
    bready <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tick(1);
    wait_sig(1, 1'b1);
    arvalid <= 1'b0;
    d = rdata;
    r = rresp;
    tick(1);
    rready <= 1'b0;
    tick(1);
  endtask : rd
  task automatic chk_res(input logic [15:0] e);
    rd(5'h0c);
    chk("result high", {24'h0, e[15:8]}, d);
    rd(5'h08);
    chk("result low", {24'h0, e[7:0]}, d);
  endtask : chk_res
  task automatic pulse(input logic [3:0] i);
    trig <= 6'h1 << i;
    tick(1);
    trig <= '0;
    tick(5);
  endtask : pulse
  // -----------------------------------------
  // sequence
  // -----------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    rd(5'h00);
    chk("ctrl reset", 32'h0, d);
    rd(5'h04);
    chk("cfg reset", 32'h1f, d);
    rd(5'h10);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(5'h00, 32'hff, 4'h1);
    rd(5'h00);
    chk("ctrl fields", 32'h7f, d);
    wr(5'h00, 32'h0, 4'h1);
    wr(5'h04, 32'h0, 4'h7);
    code_set <= 10'h3ff;
    wr(5'h08, 32'hff, 4'hf);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    wr(5'h10, 32'hff, 4'hf);
    chk("write error resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk_res(16'h0);
    wr(5'h00, 32'h100, 4'h3);
    rd(5'h00);
    chk("busy bit", 32'h100, d);
    chk("sar convert", 32'h1, {31'h0, sar_convert});
    chk("sar track", 32'h0, {31'h0, sar_track});
    wait_sig(3, 1'b0);
    rd(5'h00);
    chk("done bit", 32'h200, d);
    foreach (tbl[i])
    begin
      code_set <= tbl[i][33:24];
      wr(5'h04, {13'h0, tbl[i][18:16], 5'h0, tbl[i][22:20], 8'h0}, 4'h7);
      n = (tbl[i][18:16] == 3'h0) ? 1 : 2 << tbl[i][18:16];
      for (int k = 1; k <= n; k++)
      begin
        wr(5'h00, 32'h100, 4'h3);
        wait_sig(3, 1'b0);
        chk("done", {31'h0, k == n}, {31'h0, conv_done});
      end
      wait_sig(2, 1'b1);
      chk_res(tbl[i][15:0]);
    end
    // single-sample series so trigger runs leave no partial count behind
    wr(5'h04, 32'h0, 4'h7);
    foreach (trg[i])
    begin
      t16 <= trg[i][8];
      wr(5'h00, {29'h0, trg[i][14:12]}, 4'h1);
      pulse(trg[i][7:4]);
      chk("ignored source", 32'h0, {31'h0, conv_busy});
      pulse(trg[i][3:0]);
      chk("source start", 32'h1, {31'h0, conv_busy});
      wait_sig(3, 1'b0);
    end
    code_set <= 10'h100;
    wr(5'h04, 32'h10000, 4'h7);
    // software mode must be in place before the start write
    wr(5'h00, 32'h18, 4'h1);
    wr(5'h00, 32'h118, 4'h3);
    wait_sig(2, 1'b1);
    chk_res(16'h400);
    wr(5'h04, 32'h0, 4'h7);
    // sync and tracking set first so the start waits for a sync pulse
    wr(5'h00, 32'h70, 4'h1);
    wr(5'h00, 32'h170, 4'h3);
    wait_sig(2, 1'b1);
    chk_res(16'h100);
    print_verdict();
  end
endmodule : tb_sac_top
